// ==== phy_mode_pin_mux_and_leds_test.sv ====
`timescale 1ns/1ps
module phy_mode_pin_mux_and_leds_test;
  import pmpl_pkg::*;
  localparam int unsigned BLK = 20;
  logic        clk, rst_b, psel, pen, pwr, sysn, strap, tdo, link, fdx, act, wake;
  logic        pready, pslverr, tdo_pin, tdo_oe, ext, pd, sys_rst, clr, wsel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  jpins, pdata, rxd, spin, jtag, mii;
  logic [1:0]  gp_in, gp_o, gp_oe, gp_ext, d;
  logic [64:0] q[$];
  logic [64:0] cur;
  logic [3:0]  modes [3] = '{4'h3, 4'hf, 4'h0};
  int          fail_count, check_count, clr_cnt, rst_cnt, n;

  assign spin  = ext ? rxd : jpins;
  assign gp_in = (gp_oe & gp_o) | (~gp_oe & gp_ext);

  pmpl_top #(.BLINK_CYCLES(BLK)) i_pmpl_top (
    .ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .shared_pin_i(spin), .tdo_pin_o(tdo_pin), .tdo_pin_oe_o(tdo_oe), .gp_pin_i(gp_in),
    .gp_pin_o(gp_o), .gp_pin_oe_o(gp_oe), .system_reset_n_i(sysn), .phy_source_strap_i(strap),
    .jtag_tdo_i(tdo), .jtag_o(jtag), .mii_rxd_o(mii), .link_up_i(link), .full_duplex_i(fdx),
    .activity_i(act), .wake_event_i(wake), .ext_phy_mode_o(ext), .int_phy_pd_o(pd),
    .sys_reset_o(sys_rst), .wake_event_clear_o(clr), .wake_mode_select_o(wsel));

  pmpl_phy_model i_pmpl_phy_model (
    .ref_clk_i(clk), .phy_reset_n_i(tdo_pin), .data_i(pdata), .rxd_o(rxd));

  // ------------------------------
  // Clock, tasks
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task end_sim();
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task settle(input int c);
    repeat (c) @(posedge clk);
  endtask : settle

  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic [64:0] e);
    q.push_back(e);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= dat;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 65'h0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, m, e});
  endtask : rd

  // ------------------------------
  // Result monitor
  // ------------------------------
  always @(posedge clk) begin
    if (sys_rst === 1'b1) rst_cnt++;
    if (clr === 1'b1) clr_cnt++;
    if (psel && pen && pready === 1'b1 && q.size() > 0) begin
      cur = q.pop_front();
      check(32'(pslverr), 32'(cur[64]));
      check(prdata & cur[63:32], cur[31:0]);
    end
  end

  initial begin
    settle(20000);
    fail_count++;
    end_sim();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(70));
    {rst_b, psel, pen, pwr, sysn, strap, tdo, link, fdx, act, wake} = 11'h040;
    {paddr, pwdata, jpins, pdata, gp_ext} = '0;
    {fail_count, check_count, clr_cnt, rst_cnt} = '0;
    settle(2);
    rst_b <= 1'b1;
    settle(8);
    rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    check(gp_oe, 2'h0);
    rd(ADDR_STAT, 32'h3, 32'h0);
    apb(1'b0, 12'h008, 32'h0, {1'b1, 64'h0});
    jpins <= 4'($urandom);
    tdo   <= 1'($urandom);
    settle(8);
    check(jtag, jpins);
    check({mii, tdo_pin, tdo_oe}, {4'h0, tdo, 1'b1});
    for (int m = 0; m < 3; m++) begin
      d = 2'($urandom);
      wr(ADDR_CTRL, {24'h0, d, modes[m], 2'b00});
      settle(2);
      check(gp_oe, m == 0 ? 2'h3 : m == 1 ? 2'(~d) : 2'h0);
      check(gp_o & gp_oe, m == 0 ? d : 2'h0);
    end
    gp_ext <= 2'($urandom);
    settle(8);
    rd(ADDR_STAT, 32'h18, {27'h0, gp_ext, 3'h0});
    wr(ADDR_CTRL, 32'h3);
    link <= 1'b1;
    fdx  <= 1'b1;
    settle(4);
    check({gp_oe, gp_o}, 4'hc);
    fdx <= 1'b0;
    settle(3);
    check(gp_oe, 2'h2);
    act <= 1'b1;
    n = 0;
    while (gp_oe[1] !== 1'b0 && n < 50) begin
      settle(1);
      n++;
    end
    n = 0;
    while (gp_oe[1] === 1'b0 && n < 100) begin
      settle(1);
      n++;
    end
    check(n, BLK);
    n = 0;
    while (gp_oe[1] === 1'b1 && n < 100) begin
      settle(1);
      n++;
    end
    check(n >= BLK && n < 100, 1'b1);
    {act, link} <= 2'h0;
    strap <= 1'b1;
    settle(6);
    sysn <= 1'b0;
    settle(8);
    check(sys_rst, 1'b1);
    sysn <= 1'b1;
    settle(16);
    check({ext, pd}, 2'h2);
    rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    pdata <= 4'($urandom);
    settle(8);
    check({mii, jtag, tdo_pin}, {pdata, 4'h0, 1'b1});
    wr(ADDR_CTRL, 32'h400);
    settle(8);
    check({mii, tdo_pin}, 5'h0);
    wr(ADDR_CTRL, 32'h300);
    wake   <= 1'b1;
    gp_ext <= 2'($urandom);
    settle(8);
    check({gp_oe[0], gp_o[0]}, 2'h3);
    check(wsel, gp_ext[1]);
    {clr_cnt, rst_cnt} = '0;
    sysn <= 1'b0;
    settle(8);
    sysn <= 1'b1;
    settle(8);
    check(clr_cnt, 32'h1);
    check(rst_cnt, 32'h0);
    rst_b <= 1'b0;
    settle(2);
    rst_b <= 1'b1;
    settle(10);
    check({pd, ext}, 2'h3);
    rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    end_sim();
  end
endmodule : phy_mode_pin_mux_and_leds_test

// ==== pmpl_phy_model.sv ====
`timescale 1ns/1ps
module pmpl_phy_model
  import pmpl_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       phy_reset_n_i,
  input  wire logic [3:0] data_i,
  output logic      [3:0] rxd_o
);
  // ------------------------------
  // Receive data, pulled low in reset
  // ------------------------------
  always @(posedge ref_clk_i) begin
    rxd_o <= phy_reset_n_i ? data_i : 4'h0;
  end
endmodule : pmpl_phy_model

// ==== pmpl_pkg.sv ====
package pmpl_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned BLINK_MS     = 80;
  localparam int unsigned BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [2:0]  STRAP_SETTLE = 3'h4;

  localparam int unsigned AW        = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;

  // Synchronised pin vector positions
  localparam int unsigned PIN_TRST  = 0;
  localparam int unsigned PIN_TCK   = 1;
  localparam int unsigned PIN_TMS   = 2;
  localparam int unsigned PIN_TDI   = 3;
  localparam int unsigned PIN_GP8   = 4;
  localparam int unsigned PIN_GP9   = 5;
  localparam int unsigned PIN_SYS   = 6;
  localparam int unsigned PIN_STRAP = 7;
  localparam int unsigned NPIN      = 8;

  // Control register layout, lsb last; reset value is all zero
  localparam int unsigned CTRL_W   = 11;
  typedef struct packed {
    logic       phy_rst;
    logic       wake_pin_en;
    logic       wake_mode_en;
    logic [1:0] gpio_out;
    logic [1:0] gpio_od;
    logic [1:0] gpio_dir;
    logic [1:0] led_en;
  } pmpl_ctrl_s;
  localparam pmpl_ctrl_s CTRL_RST = 11'h000;

  typedef enum logic [1:0] {
    BL_IDLE,
    BL_DARK,
    BL_HOLD
  } pmpl_blink_e;

endpackage : pmpl_pkg

// ==== pmpl_top.sv ====
`timescale 1ns/1ps
module pmpl_top
  import pmpl_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [AW-1:0]   paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire logic [3:0]      shared_pin_i,
  output logic                 tdo_pin_o,
  output logic                 tdo_pin_oe_o,
  input  wire logic [1:0]      gp_pin_i,
  output logic      [1:0]      gp_pin_o,
  output logic      [1:0]      gp_pin_oe_o,
  input  wire logic            system_reset_n_i,
  input  wire logic            phy_source_strap_i,
  input  wire logic            jtag_tdo_i,
  output logic      [3:0]      jtag_o,
  output logic      [3:0]      mii_rxd_o,
  input  wire logic            link_up_i,
  input  wire logic            full_duplex_i,
  input  wire logic            activity_i,
  input  wire logic            wake_event_i,
  output logic                 ext_phy_mode_o,
  output logic                 int_phy_pd_o,
  output logic                 sys_reset_o,
  output logic                 wake_event_clear_o,
  output logic                 wake_mode_select_o
);

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] f;
    pmpl_ctrl_s      ctrl;
    logic            pending;
    logic            por;
    logic [2:0]      settle;
    logic            ext;
    logic            pd;
    pmpl_blink_e     st;
    logic [31:0]     cnt;
    logic [3:0]      jtag;
    logic [3:0]      rxd;
    logic            tdo_pin;
    logic            tdo_oe;
    logic            sys_rst;
    logic            wake_clr;
    logic            wake_sel;
    logic [1:0]      gp_o;
    logic [1:0]      gp_oe;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } pmpl_state_s;

  pmpl_state_s q_r;
  pmpl_state_s q_nxt;

  // Returns {oe, out} for one shared I/O pin
  function automatic logic [1:0] pin_drive(
    input logic led_en,
    input logic led_n,
    input logic dir,
    input logic od,
    input logic out
  );
    logic [1:0] r;
    r = 2'h0;
    if (led_en) begin
      r = {!led_n, 1'b0};
    end else if (!dir) begin
      r = 2'h0;
    end else if (od) begin
      r = {!out, 1'b0};
    end else begin
      r = {1'b1, out};
    end
    return r;
  endfunction : pin_drive

  logic            acc;
  logic            sys_lo;
  logic            in_rst;
  logic            wake_on;
  logic [1:0]      led_n;
  logic [1:0]      drv;
  logic [31:0]     cyc_m1;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    q_nxt   = q_r;
    cyc_m1  = BLINK_CYCLES - 32'h1;
    drv     = 2'h0;
    q_nxt.s1 = {phy_source_strap_i, system_reset_n_i, gp_pin_i, shared_pin_i};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.f  = (q_r.s2 & q_r.s3) | (q_r.f & (q_r.s2 | q_r.s3));

    sys_lo  = !q_r.f[PIN_SYS];
    in_rst  = sys_lo && !q_r.ctrl.wake_mode_en;
    wake_on = q_r.ext && q_r.ctrl.wake_mode_en;

    // APB slave, one wait state
    acc            = psel_i && penable_i;
    q_nxt.pready   = acc && !q_r.pready;
    q_nxt.pslverr  = 1'b0;
    q_nxt.prdata   = 32'h0;
    if (acc && !q_r.pready && !pwrite_i) begin
      unique case (paddr_i)
        ADDR_CTRL: q_nxt.prdata = {21'h0, q_r.ctrl};
        ADDR_STAT: q_nxt.prdata = {25'h0, sys_lo, q_r.st == BL_DARK,
                                   q_r.f[PIN_GP9:PIN_GP8], q_r.pending,
                                   q_r.pd, q_r.ext};
        default:   q_nxt.pslverr = 1'b1;
      endcase
    end else if (acc && !q_r.pready) begin
      q_nxt.pslverr = (paddr_i != ADDR_CTRL) && (paddr_i != ADDR_STAT);
    end
    if (acc && q_r.pready && pwrite_i && paddr_i == ADDR_CTRL) begin
      q_nxt.ctrl = pmpl_ctrl_s'(pwdata_i[CTRL_W-1:0]);
    end

    // System reset pin or wake-event clear
    q_nxt.sys_rst  = in_rst;
    q_nxt.wake_clr = q_r.ctrl.wake_mode_en && q_r.f[PIN_SYS]
                     && !q_nxt.f[PIN_SYS];

    // Strap capture after power-on and at each reset assertion
    if (in_rst && !q_r.sys_rst) begin
      q_nxt.pending = 1'b1;
      q_nxt.settle  = 3'h0;
      q_nxt.por     = 1'b0;
    end else if (q_r.pending) begin
      if (q_r.settle == STRAP_SETTLE) begin
        q_nxt.pending = 1'b0;
        q_nxt.ext     = q_r.f[PIN_STRAP];
        if (q_r.por) begin
          q_nxt.pd = q_r.f[PIN_STRAP];
        end
      end else begin
        q_nxt.settle = q_r.settle + 3'h1;
      end
    end

    // Shared scan pins
    if (q_r.ext) begin
      q_nxt.rxd     = q_r.f[PIN_TDI:PIN_TRST];
      q_nxt.jtag    = 4'h0;
      q_nxt.tdo_pin = !(q_r.ctrl.phy_rst || in_rst
                        || q_r.pending);
    end else begin
      q_nxt.rxd     = 4'h0;
      q_nxt.jtag    = q_r.f[PIN_TDI:PIN_TRST];
      q_nxt.tdo_pin = q_r.pending ? 1'b0 : jtag_tdo_i;
    end
    q_nxt.tdo_oe = 1'b1;

    // Activity blink timing
    unique case (q_r.st)
      BL_IDLE: begin
        if (link_up_i && activity_i) begin
          q_nxt.st  = BL_DARK;
          q_nxt.cnt = cyc_m1;
        end
      end
      BL_DARK: begin
        if (q_r.cnt == 32'h0) begin
          q_nxt.st  = BL_HOLD;
          q_nxt.cnt = cyc_m1;
        end else begin
          q_nxt.cnt = q_r.cnt - 32'h1;
        end
      end
      BL_HOLD: begin
        if (q_r.cnt == 32'h0) begin
          q_nxt.st = BL_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 32'h1;
        end
      end
    endcase
    if (!link_up_i || in_rst) begin
      q_nxt.st  = BL_IDLE;
      q_nxt.cnt = 32'h0;
    end

    led_n[0] = !(link_up_i && full_duplex_i);
    led_n[1] = !link_up_i || (q_nxt.st == BL_DARK);

    // Shared indicator / I/O pins
    for (int i = 0; i < 2; i++) begin
      drv = pin_drive(q_r.ctrl.led_en[i], led_n[i], q_r.ctrl.gpio_dir[i],
                      q_r.ctrl.gpio_od[i], q_r.ctrl.gpio_out[i]);
      q_nxt.gp_oe[i] = drv[1];
      q_nxt.gp_o[i]  = drv[0];
    end
    if (wake_on && q_r.ctrl.wake_pin_en) begin
      q_nxt.gp_oe = 2'b01;
      q_nxt.gp_o  = {1'b0, wake_event_i};
    end
    q_nxt.wake_sel = wake_on && q_r.ctrl.wake_pin_en
                     && q_r.f[PIN_GP9];

    if (in_rst) begin
      q_nxt.ctrl = CTRL_RST;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_r         <= '0;
      q_r.pending <= 1'b1;
      q_r.por     <= 1'b1;
      q_r.tdo_oe  <= 1'b1;
      q_r.s1[PIN_SYS] <= 1'b1;
      q_r.s2[PIN_SYS] <= 1'b1;
      q_r.s3[PIN_SYS] <= 1'b1;
      q_r.f[PIN_SYS]  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata_o           = q_r.prdata;
  assign pready_o           = q_r.pready;
  assign pslverr_o          = q_r.pslverr;
  assign tdo_pin_o          = q_r.tdo_pin;
  assign tdo_pin_oe_o       = q_r.tdo_oe;
  assign gp_pin_o           = q_r.gp_o;
  assign gp_pin_oe_o        = q_r.gp_oe;
  assign jtag_o             = q_r.jtag;
  assign mii_rxd_o          = q_r.rxd;
  assign ext_phy_mode_o     = q_r.ext;
  assign int_phy_pd_o       = q_r.pd;
  assign sys_reset_o        = q_r.sys_rst;
  assign wake_event_clear_o = q_r.wake_clr;
  assign wake_mode_select_o = q_r.wake_sel;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence dark_start_s;
    q_r.st == BL_IDLE ##1 q_r.st == BL_DARK;
  endsequence

  sequence dark_run_s;
    (link_up_i && !in_rst) [*8];
  endsequence

  sequence hold_start_s;
    q_r.st == BL_DARK ##1 q_r.st == BL_HOLD;
  endsequence

  // --------------------------------------------------------------------
  // Straps, scan pins and system reset
  // --------------------------------------------------------------------
  strap_hold_a: assert property (!q_r.pending && !$past(q_r.pending)
    |-> $stable(q_r.ext)) else $error("strap changed while held");
  strap_take_a: assert property (q_r.pending && q_r.settle == STRAP_SETTLE && !in_rst
    |=> ext_phy_mode_o == $past(q_r.f[PIN_STRAP]) && !q_r.pending) else $error("strap not captured");
  mode_scan_a: assert property (!q_r.ext && !q_r.pending
    |=> jtag_o == $past(q_r.f[3:0]) && mii_rxd_o == 4'h0)
    else $error("scan port not routed");
  tdo_scan_a: assert property (!q_r.ext && !q_r.pending
    |=> tdo_pin_o == $past(jtag_tdo_i)) else $error("scan data out not routed");
  mode_rxd_a: assert property (q_r.ext |=> mii_rxd_o == $past(q_r.f[3:0]))
    else $error("rx data not routed");
  power_down_a: assert property (q_r.pending && q_r.por && q_r.settle == STRAP_SETTLE
    && q_r.f[PIN_STRAP] && !in_rst |=> int_phy_pd_o)
    else $error("internal phy not powered down");
  phy_reset_a: assert property (q_r.ext && !q_r.pending && q_r.ctrl.phy_rst
    |=> !tdo_pin_o) else $error("phy reset not driven");
  phy_hold_a: assert property (q_r.ext && (in_rst || q_r.pending)
    |=> !tdo_pin_o) else $error("phy reset not held");
  sys_reset_a: assert property (!q_r.f[PIN_SYS] && !q_r.ctrl.wake_mode_en
    |=> sys_reset_o && q_r.ctrl == CTRL_RST) else $error("reset ignored");

  // --------------------------------------------------------------------
  // Indicators and wake pins
  // --------------------------------------------------------------------
  wake_clear_a: assert property (q_r.ctrl.wake_mode_en && $fell(q_r.f[PIN_SYS])
    |-> wake_event_clear_o && !sys_reset_o) else $error("wake clear missed");
  wake_drive_a: assert property (wake_on && q_r.ctrl.wake_pin_en
    |=> gp_pin_oe_o == 2'b01 && gp_pin_o[0] == $past(wake_event_i)) else $error("wake pin not driven");
  wake_select_a: assert property (wake_on && q_r.ctrl.wake_pin_en
    |=> wake_mode_select_o == $past(q_r.f[PIN_GP9])) else $error("wake select not sampled");
  duplex_led_a: assert property (q_r.ctrl.led_en[0] && !wake_on && !in_rst
    |=> gp_pin_oe_o[0] == $past(link_up_i && full_duplex_i) && !gp_pin_o[0])
    else $error("duplex led wrong");
  link_lit_a: assert property (q_r.ctrl.led_en[1] && !wake_on && link_up_i && !activity_i
    && q_r.st != BL_DARK |=> gp_pin_oe_o[1] && !gp_pin_o[1])
    else $error("link led not lit");
  link_dark_a: assert property (q_r.ctrl.led_en[1] && !wake_on && !link_up_i
    |=> !gp_pin_oe_o[1]) else $error("link led lit without link");
  blink_start_a: assert property (q_r.st == BL_IDLE && link_up_i && activity_i && !in_rst
    |=> q_r.st == BL_DARK && q_r.cnt == BLINK_CYCLES - 32'h1) else $error("blink not started");
  blink_dark_a: assert property (dark_start_s ##0 dark_run_s
    |-> q_r.st == BL_DARK) else $error("dark pulse too short");
  hold_min_a: assert property (hold_start_s ##0 dark_run_s
    |-> q_r.st == BL_HOLD) else $error("lit pause too short");
  blink_hold_a: assert property (q_r.st == BL_HOLD && q_r.cnt != 32'h0
    |=> q_r.st != BL_DARK) else $error("blink restarted early");
  blink_drop_a: assert property (!link_up_i
    |=> q_r.st == BL_IDLE) else $error("blink kept without link");

  // --------------------------------------------------------------------
  // I/O pins and register bus
  // --------------------------------------------------------------------
  gpio_od_a: assert property (!q_r.ctrl.led_en[1] && q_r.ctrl.gpio_dir[1]
    && q_r.ctrl.gpio_od[1] && !(wake_on && q_r.ctrl.wake_pin_en) && !in_rst
    |=> gp_pin_oe_o[1] == !$past(q_r.ctrl.gpio_out[1]) && !gp_pin_o[1])
    else $error("open drain wrong");
  gpio_push_a: assert property (!q_r.ctrl.led_en[0] && q_r.ctrl.gpio_dir[0]
    && !q_r.ctrl.gpio_od[0] && !(wake_on && q_r.ctrl.wake_pin_en)
    |=> gp_pin_oe_o[0] && gp_pin_o[0] == $past(q_r.ctrl.gpio_out[0])) else $error("push pull wrong");
  gpio_input_a: assert property (!q_r.ctrl.led_en[1] && !q_r.ctrl.gpio_dir[1]
    |=> !gp_pin_oe_o[1]) else $error("input pin driven");
  apb_ready_a: assert property (psel_i && penable_i && !pready_o
    |=> pready_o) else $error("no apb answer");
  apb_error_a: assert property (psel_i && penable_i && !pready_o
    && paddr_i != ADDR_CTRL && paddr_i != ADDR_STAT
    |=> pslverr_o) else $error("unmapped access accepted");
  ctrl_write_a: assert property (psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_CTRL && !in_rst
    |=> q_r.ctrl == $past(pwdata_i[CTRL_W-1:0])) else $error("control write lost");

endmodule : pmpl_top
